// File: panel_inputs.sv
`timescale 1ns/10ps
`include "panel_map.svh"
// Summary of operation
// RQ1: Every keylock position has its own pair of inputs, channel A and B.
// RQ2: Keylock inputs evaluated as two channels; position-to-mode map is software set.
// RQ3: Power loss, missing test supply or broken wire selects protective mode one.
// RQ4: Forced test drives each test supply low and checks its inputs fall low.
// RQ5: Switch gives two contacts each for protective modes two and three.
// RQ6: Protective mode four comes from an extra keylock switch.
// RQ7: A mode is selected only when both channels agree.
// RQ8: Each operating key gives two normally-open contacts, one per channel.
// RQ9: At self-test all key inputs must read low; any high is a fault. The code checks only keys enabled in key_ena_ff.
// RQ10: All operating keys are combined into one group signal for self-test.
// RQ11: A key acts only when both of its contacts are closed.
// RQ12: Stop key contact A goes to main controller, contact B to drive controller.
// RQ13: Stop-key polarity per channel is configurable; inverted is the default.
// RQ14: With inverted polarity a stop acts when either channel sees it pressed.
// RQ15: A stop press requests a monitored controlled stop.
// RQ16: Control-voltage-on channels are forwarded to the safety kernel.
// RQ17: Test supplies go low alternately with a gap between them.
// RQ18: Disagreeing keylock channels deselect the position and flag a discrepancy.
module panel_inputs
  import panel_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Panel contacts, channel A and B.
  input wire panel_pkg::panel_ch_t pins_a,
  input wire panel_pkg::panel_ch_t pins_b,
  // Test supply outputs, high while supplying.
  output logic test_supply_a,
  output logic test_supply_b,
  // Results toward main controller and drive controller.
  output panel_pkg::plc_out_t main_ctrl,
  output panel_pkg::plc_out_t drive_ctrl,
  output logic controlled_stop_monitored,
  // Interrupt.
  output logic irq
);
  import panel_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int PW = $bits(panel_ch_t);
  panel_ch_t sa, sb;
  pin_sync #(.W(PW)) u_sync_a (.hclk(hclk), .hresetn(hresetn), .d(pins_a), .q(sa));
  pin_sync #(.W(PW)) u_sync_b (.hclk(hclk), .hresetn(hresetn), .d(pins_b), .q(sb));

  // Map position bit p of the keylock field to a mode via a 2-bit map entry.
  function automatic prot_mode_t map_mode(input logic [31:0] mp, input logic [1:0] p);
    map_mode = prot_mode_t'(mp[{p, 1'b0} +: 2]);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] mode_map_ff;
  logic [7:0] pol_a_ff, pol_b_ff;
  logic [15:0] key_ena_ff;
  logic [`ST_WIDTH-1:0] status_ff, mask_ff;
  logic [31:0] hrdata_ff;
  logic [11:0] addr_ff;
  logic wr_ff, rd_ff;

  wire acc = hsel & hready & htrans[1];
  wire wr_ctrl = wr_ff & (addr_ff == `OFS_CTRL);
  wire wr_status = wr_ff & (addr_ff == `OFS_STATUS);
  wire wr_mask = wr_ff & (addr_ff == `OFS_MASK);
  wire wr_map = wr_ff & (addr_ff == `OFS_MODE_MAP);
  wire wr_pol = wr_ff & (addr_ff == `OFS_STOP_POL);
  wire wr_ena = wr_ff & (addr_ff == `OFS_KEY_ENA);

  // ----------------------------------------------------------------
  // Test sequencer
  // ----------------------------------------------------------------
  localparam int SETTLE = (`TEST_SETTLE_CYC < 1) ? 1 : `TEST_SETTLE_CYC;
  localparam int GAP = (`TEST_GAP_CYC < 1) ? 1 : `TEST_GAP_CYC;
  test_state_t ts_ff, nxt_ts;
  logic [7:0] cnt_ff, nxt_cnt;
  logic test_fail_ff, selftest_ff;
  wire cnt_end = (cnt_ff == 8'h00);
  wire start = wr_ctrl & hwdata[`CTRL_TEST_START];
  // The check accepts only a fully dead channel; any contact left high means a
  // wire or contact bridging to another supply.
  wire a_dead = (sa == '0);
  wire b_dead = (sb == '0);
  wire chk_fail = ((ts_ff == ts_a_low) & cnt_end & ~a_dead) |
                  ((ts_ff == ts_b_low) & cnt_end & ~b_dead); // [RQ4]

  always_comb begin
    nxt_ts = ts_ff;
    nxt_cnt = cnt_end ? 8'h00 : cnt_ff - 8'h01;
    unique case (ts_ff)
      ts_idle: begin
        if (start) begin
          nxt_ts = ts_a_low;
          nxt_cnt = 8'(SETTLE);
        end
      end
      ts_a_low: begin
        if (cnt_end) begin
          nxt_ts = ts_gap;
          nxt_cnt = 8'(GAP);
        end
      end
      ts_gap: begin
        if (cnt_end) begin
          nxt_ts = ts_b_low; // [RQ17]
          nxt_cnt = 8'(SETTLE);
        end
      end
      ts_b_low: begin
        if (cnt_end) begin
          nxt_ts = ts_done;
        end
      end
      ts_done: nxt_ts = ts_idle;
      default: nxt_ts = ts_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_ff <= ts_idle;
      cnt_ff <= 8'h00;
    end else begin
      ts_ff <= nxt_ts;
      cnt_ff <= nxt_cnt;
    end
  end

  // Only one supply is ever off, so the other channel keeps evaluating.
  assign test_supply_a = (ts_ff != ts_a_low); // [RQ17]
  assign test_supply_b = (ts_ff != ts_b_low); // [RQ17]
  // Channel B's synchroniser still holds the test zeros for one cycle after the
  // done state, so results stay frozen through that cycle to avoid a false discrepancy.
  logic post_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_ff <= 1'b0;
    end else begin
      post_ff <= (ts_ff == ts_done);
    end
  end
  wire testing = (ts_ff == ts_a_low) | (ts_ff == ts_gap) | (ts_ff == ts_b_low) |
                 (ts_ff == ts_done) | post_ff;

  // ----------------------------------------------------------------
  // Keylock evaluation
  // ----------------------------------------------------------------
  // Channel under test reads low by design; hold the last result meanwhile.
  wire [3:0] kl_agree = sa.keylock & sb.keylock; // [RQ7] [RQ1]
  wire discrep = ~testing & |(sa.keylock ^ sb.keylock); // [RQ18]
  prot_mode_t mode_ff, nxt_mode;
  always_comb begin
    nxt_mode = prot_mode_1; // [RQ3]
    for (int p = 0; p < 4; p++) begin
      if (kl_agree[p]) begin
        nxt_mode = map_mode(mode_map_ff, 2'(p)); // [RQ2]
      end
    end
    // Two agreed positions at once is a broken switch; stay protective.
    if (discrep | test_fail_ff | ($countones(kl_agree) > 1)) begin
      nxt_mode = prot_mode_1; // [RQ18] [RQ3]
    end
    if (testing) begin
      nxt_mode = mode_ff;
    end
  end

  // ----------------------------------------------------------------
  // Operating keys and stop keys
  // ----------------------------------------------------------------
  wire [15:0] keys_both = sa.keys & sb.keys & key_ena_ff; // [RQ11]
  wire keys_any = |((sa.keys | sb.keys) & key_ena_ff); // [RQ10]
  wire key_stuck = selftest_ff & ~testing & keys_any; // [RQ9]
  // Polarity bit 1 inverts: marker reads 1 while the key is released.
  wire [7:0] mark_a = sa.stops ^ pol_a_ff; // [RQ13]
  wire [7:0] mark_b = sb.stops ^ pol_b_ff; // [RQ13]
  wire [7:0] stop_a = pol_a_ff & ~mark_a | ~pol_a_ff & mark_a & mark_b; // [RQ12]
  wire [7:0] stop_b = pol_b_ff & ~mark_b | ~pol_b_ff & mark_a & mark_b; // [RQ12]
  wire [7:0] stop_any = stop_a | stop_b; // [RQ14]

  plc_out_t main_ff, drive_ff;
  logic css_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= prot_mode_1;
      main_ff <= '0;
      drive_ff <= '0;
      css_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      main_ff <= '{nxt_mode, keys_both, stop_a, sa.cvo, keys_any}; // [RQ16] [RQ10]
      drive_ff <= '{nxt_mode, keys_both, stop_b, sb.cvo, keys_any}; // [RQ16] [RQ10]
      css_ff <= |stop_any; // [RQ15]
    end
  end
  assign main_ctrl = main_ff;
  assign drive_ctrl = drive_ff;
  assign controlled_stop_monitored = css_ff;

  // ----------------------------------------------------------------
  // Events and status
  // ----------------------------------------------------------------
  logic [`ST_WIDTH-1:0] ev;
  always_comb begin
    ev = '0;
    ev[`ST_TEST_FAULT] = chk_fail;
    ev[`ST_DISCREP] = discrep;
    ev[`ST_KEY_STUCK] = key_stuck;
    ev[`ST_MODE_CHG] = (nxt_mode != mode_ff);
    ev[`ST_STOP] = |stop_any & ~css_ff;
    ev[`ST_TEST_DONE] = (ts_ff == ts_done);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= '0;
      test_fail_ff <= 1'b0;
      selftest_ff <= 1'b0;
    end else begin
      // Set wins over a write-one clear in the same cycle.
      status_ff <= (status_ff & ~(wr_status ? hwdata[`ST_WIDTH-1:0] : '0)) | ev;
      if (chk_fail) begin
        test_fail_ff <= 1'b1; // [RQ3]
      end else if (start) begin
        test_fail_ff <= 1'b0;
      end
      if (wr_ctrl) begin
        selftest_ff <= hwdata[`CTRL_SELFTEST];
      end
    end
  end
  assign irq = |(status_ff & mask_ff);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [31:0] rdmux;
  always_comb begin
    rdmux = 32'h0000_0000;
    unique case (addr_ff)
      `OFS_CTRL: rdmux = {30'h0, selftest_ff, testing};
      `OFS_STATUS: rdmux = 32'(status_ff);
      `OFS_MASK: rdmux = 32'(mask_ff);
      `OFS_MODE_MAP: rdmux = mode_map_ff;
      `OFS_STOP_POL: rdmux = {16'h0, pol_b_ff, pol_a_ff};
      `OFS_KEY_ENA: rdmux = {16'h0, key_ena_ff};
      `OFS_STATE: rdmux = {24'h0, test_fail_ff, ts_ff, 2'h0, mode_ff};
      `OFS_KEYS: rdmux = {sb.keys, sa.keys};
      `OFS_STOPS: rdmux = {7'h0, sb.cvo, 7'h0, sa.cvo, sb.stops, sa.stops};
      default: rdmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 12'h000;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
      mode_map_ff <= `RST_MODE_MAP;
      pol_a_ff <= `RST_STOP_POL;
      pol_b_ff <= `RST_STOP_POL;
      key_ena_ff <= `RST_KEY_ENA;
      mask_ff <= '0;
    end else begin
      wr_ff <= acc & hwrite;
      rd_ff <= acc & ~hwrite;
      if (acc) begin
        addr_ff <= haddr;
      end
      if (rd_ff) begin
        hrdata_ff <= rdmux;
      end
      if (wr_map) mode_map_ff <= hwdata;
      if (wr_pol) begin
        pol_a_ff <= hwdata[7:0];
        pol_b_ff <= hwdata[15:8];
      end
      if (wr_ena) key_ena_ff <= hwdata[15:0];
      if (wr_mask) mask_ff <= hwdata[`ST_WIDTH-1:0];
    end
  end

  // Reads take one wait state so read data come from a register.
  assign hreadyout = ~rd_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;
endmodule // panel_inputs

// File: panel_map.svh
`ifndef PANEL_MAP_SVH
`define PANEL_MAP_SVH
// Register byte offsets.
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_MASK 12'h008
`define OFS_MODE_MAP 12'h00c
`define OFS_STOP_POL 12'h010
`define OFS_KEY_ENA 12'h014
`define OFS_STATE 12'h018
`define OFS_KEYS 12'h01c
`define OFS_STOPS 12'h020
// Control register fields.
`define CTRL_TEST_START 0
`define CTRL_SELFTEST 1
// Status register fields.
`define ST_TEST_FAULT 0
`define ST_DISCREP 1
`define ST_KEY_STUCK 2
`define ST_MODE_CHG 3
`define ST_STOP 4
`define ST_TEST_DONE 5
`define ST_WIDTH 6
// Reset values.
`define RST_MODE_MAP 32'h0000_0e4d
`define RST_STOP_POL 8'hff
`define RST_KEY_ENA 16'hffff
// Timing: settle delay before test check, and gap between channels.
`define TEST_SETTLE_NS 200
`define TEST_GAP_NS 400
`define CLK_PERIOD_NS 8
`define TEST_SETTLE_CYC ((`TEST_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TEST_GAP_CYC ((`TEST_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: panel_pkg.sv
package panel_pkg;
  typedef enum logic [1:0] {
    prot_mode_1 = 2'h0,
    prot_mode_2 = 2'h1,
    prot_mode_3 = 2'h2,
    prot_mode_4 = 2'h3
  } prot_mode_t;
  typedef enum logic [2:0] {
    ts_idle = 3'h0,
    ts_a_low = 3'h1,
    ts_gap = 3'h3,
    ts_b_low = 3'h2,
    ts_done = 3'h6
  } test_state_t;
  // Raw dual-channel contacts from the panel.
  typedef struct packed {
    logic [3:0] keylock;
    logic [15:0] keys;
    logic [7:0] stops;
    logic cvo;
  } panel_ch_t;
  // Results toward one safety PLC channel.
  typedef struct packed {
    prot_mode_t mode;
    logic [15:0] keys;
    logic [7:0] stop_req;
    logic cvo;
    logic keys_group;
  } plc_out_t;
endpackage

// File: pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule // pin_sync

// File: panel_contacts.sv
`timescale 1ns/10ps
// ----------------------------------------
// Keylock and key contacts
// ----------------------------------------
module panel_contacts
  import panel_pkg::*;
(
  // Test supplies.
  input wire logic test_supply_a,
  input wire logic test_supply_b,
  // Contacts closed by the bench.
  input wire panel_pkg::panel_ch_t cmd_a,
  input wire panel_pkg::panel_ch_t cmd_b,
  input wire logic stuck_a,
  // Contact levels.
  output panel_pkg::panel_ch_t pins_a,
  output panel_pkg::panel_ch_t pins_b
);
  // Open contacts fed from a dead supply read low; stuck_a models a foreign feed.
  assign pins_a = (test_supply_a || stuck_a) ? cmd_a : '0;
  assign pins_b = test_supply_b ? cmd_b : '0;
endmodule // panel_contacts

// File: panel_inputs_asserts.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module panel_inputs_asserts
  import panel_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Panel side.
  input wire panel_pkg::panel_ch_t pins_a,
  input wire panel_pkg::panel_ch_t pins_b,
  input wire logic test_supply_a,
  input wire logic test_supply_b,
  input wire panel_pkg::plc_out_t main_ctrl,
  input wire panel_pkg::plc_out_t drive_ctrl,
  input wire logic controlled_stop_monitored
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire taken = hsel && hready && htrans[1];
  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_disagree;
    (pins_a.keylock != pins_b.keylock && test_supply_a && test_supply_b) [*6];
  endsequence
  a_read_one_wait: assert property (taken && !hwrite |=> s_read_wait)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_disagree_mode_one: assert property (s_disagree |=> main_ctrl.mode == prot_mode_1)
    else $error("mode kept on disagreeing channels");
  a_key_both_ch: assert property (((main_ctrl.keys | drive_ctrl.keys)
    & ~$past(pins_a.keys & pins_b.keys, 3)) == 16'h0000)
    else $error("key acted on one contact");
  a_stop_either_ch: assert property ($past(|(pins_a.stops | pins_b.stops), 3)
    |-> ##[0:1] controlled_stop_monitored)
    else $error("stop not raised");
  a_cvo_forwarded: assert property (main_ctrl.cvo == $past(pins_a.cvo, 3)
    && drive_ctrl.cvo == $past(pins_b.cvo, 3))
    else $error("cvo not forwarded");
  a_supply_alternate: assert property (test_supply_a || test_supply_b)
    else $error("both supplies off");
  a_gap_held: assert property ($rose(test_supply_a) |-> test_supply_b [*8])
    else $error("no gap between channel tests");
  a_low_span: assert property ($fell(test_supply_a) |-> !test_supply_a [*8])
    else $error("supply low phase too short");
endmodule // panel_inputs_asserts
bind panel_inputs panel_inputs_asserts chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .pins_a, .pins_b, .test_supply_a, .test_supply_b,
  .main_ctrl, .drive_ctrl, .controlled_stop_monitored);

// File: panel_inputs_tb_top.sv
`timescale 1ns/10ps
`include "panel_map.svh"
`define chk(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// ----------------------------------------
// Bench
// ----------------------------------------
module panel_inputs_tb_top;
  import panel_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, v;
  logic hreadyout, hresp, test_supply_a, test_supply_b, controlled_stop_monitored, irq;
  logic stuck_a = 1'b0;
  panel_ch_t cmd_a = '0, cmd_b = '0, pins_a, pins_b;
  plc_out_t main_ctrl, drive_ctrl;
  int errors = 0, checks_done = 0;
  wire hready = hreadyout;
  panel_inputs dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pins_a, .pins_b, .test_supply_a,
    .test_supply_b, .main_ctrl, .drive_ctrl, .controlled_stop_monitored, .irq);
  panel_contacts model (.test_supply_a, .test_supply_b, .cmd_a, .cmd_b, .stuck_a,
    .pins_a, .pins_b);
  initial begin
    forever #4 hclk = ~hclk;
  end
  // Each call starts just after a rising edge and ends on a falling edge, so that
  // callers compare outputs that have settled after the write landed.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'h2; haddr <= a; hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    v = hrdata;
    @(negedge hclk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `chk(v, e)
  endtask
  task automatic settle();
    repeat (4) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic run_test();
    int n;
    bus(1'b1, `OFS_STATUS, 32'h0000_003f);
    bus(1'b1, `OFS_CTRL, 32'h0000_0001);
    v = 32'h0;
    for (n = 0; n < 100 && v[`ST_TEST_DONE] !== 1'b1; n++) bus(1'b0, `OFS_STATUS, 32'h0);
    if (v[`ST_TEST_DONE] !== 1'b1) errors++;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`OFS_MODE_MAP, `RST_MODE_MAP);
    rd_chk(`OFS_KEY_ENA, {16'h0000, `RST_KEY_ENA});
    bus(1'b1, 12'h100, 32'hffff_ffff);
    rd_chk(12'h100, 32'h0);
    `chk(main_ctrl.mode, prot_mode_1)
    $display("reset test done");
    bus(1'b1, `OFS_MODE_MAP, 32'h0000_00e4);
    for (int i = 0; i < 4; i++) begin
      cmd_a.keylock <= 4'h1 << i; cmd_b.keylock <= 4'h1 << i;
      settle();
      `chk(main_ctrl.mode, prot_mode_t'(i))
    end
    cmd_b.keylock <= 4'h0;
    settle();
    `chk(drive_ctrl.mode, prot_mode_1)
    bus(1'b1, `OFS_MASK, 32'h0000_0002);
    `chk(irq, 1'b1)
    bus(1'b1, `OFS_MASK, 32'h0);
    `chk(irq, 1'b0)
    cmd_b.keylock <= 4'h8;
    settle();
    bus(1'b1, `OFS_STATUS, 32'h0000_003f);
    bus(1'b1, `OFS_MASK, 32'h0000_0002);
    `chk(irq, 1'b0)
    $display("mode test done");
    cmd_a.keys <= 16'h8001; cmd_a.cvo <= 1'b1; cmd_b.stops <= 8'h80;
    settle();
    `chk(main_ctrl.keys, 16'h0000)
    `chk({main_ctrl.cvo, drive_ctrl.cvo}, 2'b10)
    `chk(controlled_stop_monitored, 1'b1)
    `chk({main_ctrl.stop_req, drive_ctrl.stop_req}, 16'h0080)
    cmd_b.keys <= 16'h8001; cmd_b.stops <= 8'h00;
    settle();
    `chk(drive_ctrl.keys, 16'h8001)
    `chk(main_ctrl.keys_group, 1'b1)
    `chk(controlled_stop_monitored, 1'b0)
    bus(1'b1, `OFS_CTRL, 32'h0000_0002);
    settle();
    bus(1'b0, `OFS_STATUS, 32'h0);
    `chk(v[`ST_KEY_STUCK], 1'b1)
    bus(1'b1, `OFS_CTRL, 32'h0);
    cmd_a.keys <= 16'h0; cmd_b.keys <= 16'h0;
    $display("key test done");
    run_test();
    `chk(v[`ST_TEST_DONE:`ST_TEST_FAULT], 6'h20)
    `chk(main_ctrl.mode, prot_mode_4)
    stuck_a <= 1'b1;
    run_test();
    `chk(v[`ST_TEST_FAULT], 1'b1)
    settle();
    `chk(main_ctrl.mode, prot_mode_1)
    $display("supply test done");
    end_of_test();
  end
endmodule // panel_inputs_tb_top
